// File: flash_bus_command_host.sv
// Host controller that drives the flash bus pins from Wishbone commands
//
// Chosen here: the Wishbone register port and the register offsets.
module flash_bus_command_host
   import flash_host_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   output logic [ADDR_W-1:0] word_address_in_o,
   output logic [DATA_W-1:0] data_io_bus_o,
   output logic data_io_bus_oe_o,
   input wire logic [DATA_W-1:0] data_io_bus_i,
   output logic chip_sel_n_o,
   output logic out_gate_n_o,
   output logic write_n_o,
   output logic hard_reset_n_o
);

   // ************************************************************
   // Registers and state
   // ************************************************************
   logic [3:0] command;
   logic [ADDR_W-1:0] target_addr;
   logic [DATA_W-1:0] write_data;
   logic [DATA_W-1:0] write_data2;
   logic [DATA_W-1:0] read_data;
   logic busy;
   logic bad_command;
   logic [1:0] step;
   logic [1:0] steps_total;
   phase_type phase;
   logic [TIMER_W-1:0] timer;
   strobes_type strobes;
   // Data pin synchroniser stages
   logic [DATA_W-1:0] din_meta;
   logic [DATA_W-1:0] din_sync;
   logic [ADDR_W-1:0] next_addr;
   logic [DATA_W-1:0] next_data;
   logic bus_write;
   logic start;

   // Opcode or data word of each step of a command sequence
   function automatic logic [DATA_W-1:0] step_data(input logic [3:0] cmd, input logic [1:0] st,
                                                 input logic [DATA_W-1:0] d1, input logic [DATA_W-1:0] d2);
      step_data = {8'h00, OP_READ_ARRAY};
      unique case (cmd)
         CMD_READ_ARRAY: step_data = {8'h00, OP_READ_ARRAY};
         CMD_READ_STATUS: step_data = {8'h00, OP_READ_STATUS};
         CMD_READ_SIGNATURE: step_data = {8'h00, OP_READ_SIGNATURE};
         CMD_READ_QUERY: step_data = {8'h00, OP_READ_QUERY};
         CMD_ERASE: step_data = (st == 2'd0) ? {8'h00, OP_ERASE_SETUP} : {8'h00, OP_ERASE_CONFIRM};
         CMD_PROGRAM: step_data = (st == 2'd0) ? {8'h00, OP_PROGRAM} : d1;
         CMD_DOUBLE_PROGRAM: step_data = (st == 2'd0) ? {8'h00, OP_DOUBLE_PROGRAM} : ((st == 2'd1) ? d1 : d2);
         CMD_CLEAR_STATUS: step_data = {8'h00, OP_CLEAR_STATUS};
         CMD_SUSPEND: step_data = {8'h00, OP_SUSPEND};
         CMD_RESUME: step_data = {8'h00, OP_RESUME};
         default: step_data = {8'h00, OP_READ_ARRAY};
      endcase
   endfunction : step_data

   // Number of bus writes of each write-type command
   function automatic logic [1:0] write_count(input logic [3:0] cmd);
      unique case (cmd)
         CMD_ERASE, CMD_PROGRAM: write_count = 2'd2;
         CMD_DOUBLE_PROGRAM: write_count = 2'd3;
         default: write_count = 2'd1;
      endcase
   endfunction : write_count

   // ************************************************************
   // Step address and data
   // ************************************************************
   // Second double word address forced to the partner word
   always_comb begin
      next_data = step_data(command, step, write_data, write_data2);
      next_addr = target_addr;
      if (command == CMD_DOUBLE_PROGRAM && step == 2'd2) begin
         next_addr = {target_addr[ADDR_W-1:1], ~target_addr[0]};
      end
   end

   // Write-type command and accepted start request
   assign bus_write = (command != CMD_BUS_READ) && (command != CMD_RESET);
   assign start = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == REG_CONTROL && wb_sel_i[0]
                  && !busy && wb_dat_i[3:0] <= CMD_RESET;

   // ************************************************************
   // Wishbone slave
   // ************************************************************
   // Single cycle answer, ack dropped after one cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      end
   end

   // Register writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         target_addr <= '0;
         write_data <= '0;
         write_data2 <= '0;
         bad_command <= 1'b0;
      end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !busy) begin
         unique case (wb_adr_i)
            REG_ADDRESS: target_addr <= wb_dat_i[ADDR_W-1:0];
            REG_DATA: write_data <= wb_dat_i[DATA_W-1:0];
            REG_DATA2: write_data2 <= wb_dat_i[DATA_W-1:0];
            REG_CONTROL: bad_command <= wb_dat_i[3:0] > CMD_RESET;
            default: ;
         endcase
      end
   end

   // Register reads, unmapped offsets read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= RESET_VALUE;
      end else begin
         unique case (wb_adr_i)
            REG_CONTROL: wb_dat_o <= {28'h0, command};
            REG_ADDRESS: wb_dat_o <= {12'h0, target_addr};
            REG_DATA: wb_dat_o <= {16'h0, write_data};
            REG_DATA2: wb_dat_o <= {16'h0, write_data2};
            REG_STATUS: wb_dat_o <= {30'h0, bad_command, busy};
            REG_READ_DATA: wb_dat_o <= {16'h0, read_data};
            default: wb_dat_o <= RESET_VALUE;
         endcase
      end
   end

   // ************************************************************
   // Data input synchroniser
   // ************************************************************
   // Two flops before any logic reads the data pins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         din_meta <= '0;
         din_sync <= '0;
      end else begin
         din_meta <= data_io_bus_i;
         din_sync <= din_meta;
      end
   end

   // ************************************************************
   // Bus sequencer
   // ************************************************************
   // Phase, step and timer of the current command
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase <= PH_IDLE;
         timer <= '0;
         step <= 2'd0;
         steps_total <= 2'd1;
         command <= CMD_READ_ARRAY;
         busy <= 1'b0;
      end else begin
         unique case (phase)
            PH_IDLE: begin
               if (start) begin
                  command <= wb_dat_i[3:0];
                  steps_total <= write_count(wb_dat_i[3:0]);
                  step <= 2'd0;
                  busy <= 1'b1;
                  timer <= TIMER_W'(SETUP_CYC);
                  phase <= (wb_dat_i[3:0] == CMD_RESET) ? PH_RESET : PH_SETUP;
                  if (wb_dat_i[3:0] == CMD_RESET) begin
                     timer <= TIMER_W'(RESET_LOW_CYC);
                  end
               end
            end
            PH_SETUP: begin
               if (timer > 1) begin
                  timer <= timer - 1'b1;
               end else begin
                  phase <= bus_write ? PH_LOW : PH_READ;
                  timer <= bus_write ? TIMER_W'(STROBE_LOW_CYC) : TIMER_W'(READ_ACCESS_CYC);
               end
            end
            PH_LOW: begin
               if (timer > 1) begin
                  timer <= timer - 1'b1;
               end else begin
                  phase <= PH_HOLD;
                  timer <= TIMER_W'(HOLD_CYC);
               end
            end
            PH_READ: begin
               if (timer > 1) begin
                  timer <= timer - 1'b1;
               end else begin
                  phase <= PH_GAP;
                  timer <= TIMER_W'(HOLD_CYC);
               end
            end
            // Next write of a sequence, or back to idle
            PH_HOLD, PH_GAP: begin
               if (timer > 1) begin
                  timer <= timer - 1'b1;
               end else if (bus_write && step + 2'd1 < steps_total) begin
                  step <= step + 2'd1;
                  phase <= PH_SETUP;
                  timer <= TIMER_W'(SETUP_CYC);
               end else begin
                  phase <= PH_IDLE;
                  busy <= 1'b0;
               end
            end
            // Reset pin pulse, then recovery time
            PH_RESET: begin
               if (timer > 1) begin
                  timer <= timer - 1'b1;
               end else begin
                  phase <= PH_RECOVER;
                  timer <= TIMER_W'(RESET_RECOVER_CYC);
               end
            end
            PH_RECOVER: begin
               if (timer > 1) begin
                  timer <= timer - 1'b1;
               end else begin
                  command <= CMD_READ_ARRAY;
                  phase <= PH_IDLE;
                  busy <= 1'b0;
               end
            end
         endcase
      end
   end

   // Bus read result, taken at the end of the access window
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         read_data <= '0;
      end else if (phase == PH_READ && timer <= TIMER_W'(1)) begin
         read_data <= din_sync;
      end
   end

   // ************************************************************
   // Pin drivers, all from flip-flops
   // ************************************************************
   // Strobes, address and data registered from the phase
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strobes <= '{chip_sel_n: 1'b1, out_gate_n: 1'b1, write_n: 1'b1, hard_reset_n: 1'b1};
         data_io_bus_oe_o <= 1'b0;
         data_io_bus_o <= '0;
         word_address_in_o <= '0;
      end else begin
         word_address_in_o <= next_addr;
         data_io_bus_o <= next_data;
         strobes.hard_reset_n <= !(phase == PH_RESET);
         strobes.chip_sel_n <= !(phase == PH_SETUP || phase == PH_LOW || phase == PH_READ || phase == PH_HOLD);
         strobes.write_n <= !(phase == PH_LOW && bus_write);
         strobes.out_gate_n <= !(phase == PH_READ || (phase == PH_SETUP && !bus_write));
         data_io_bus_oe_o <= bus_write && (phase == PH_SETUP || phase == PH_LOW || phase == PH_HOLD);
      end
   end

   // Strobe pins straight from their flops
   assign chip_sel_n_o = strobes.chip_sel_n;
   assign out_gate_n_o = strobes.out_gate_n;
   assign write_n_o = strobes.write_n;
   assign hard_reset_n_o = strobes.hard_reset_n;

endmodule : flash_bus_command_host

// File: flash_host_pkg.sv
// Package with constants and types of the flash bus host controller
package flash_host_pkg;

   // ************************************************************
   // Bus geometry
   // ************************************************************
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;

   // ************************************************************
   // Command opcodes placed on the data bus
   // ************************************************************
   localparam logic [7:0] OP_READ_ARRAY = 8'hFF;
   localparam logic [7:0] OP_READ_STATUS = 8'h70;
   localparam logic [7:0] OP_READ_SIGNATURE = 8'h90;
   localparam logic [7:0] OP_READ_QUERY = 8'h98;
   localparam logic [7:0] OP_ERASE_SETUP = 8'h20;
   localparam logic [7:0] OP_ERASE_CONFIRM = 8'hD0;
   localparam logic [7:0] OP_PROGRAM = 8'h40;
   localparam logic [7:0] OP_DOUBLE_PROGRAM = 8'h30;
   localparam logic [7:0] OP_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] OP_SUSPEND = 8'hB0;
   localparam logic [7:0] OP_RESUME = 8'hD0;

   // ************************************************************
   // Status bits of the device
   // ************************************************************
   localparam int ST_READY_BIT = 7;
   localparam int ST_ERASE_ERR_BIT = 5;
   localparam int ST_PROG_ERR_BIT = 4;
   localparam int ST_VPP_ERR_BIT = 3;
   localparam int ST_LOCK_ERR_BIT = 1;

   // ************************************************************
   // Host command codes written by software
   // ************************************************************
   localparam logic [3:0] CMD_READ_ARRAY = 4'h0;
   localparam logic [3:0] CMD_READ_STATUS = 4'h1;
   localparam logic [3:0] CMD_READ_SIGNATURE = 4'h2;
   localparam logic [3:0] CMD_READ_QUERY = 4'h3;
   localparam logic [3:0] CMD_ERASE = 4'h4;
   localparam logic [3:0] CMD_PROGRAM = 4'h5;
   localparam logic [3:0] CMD_DOUBLE_PROGRAM = 4'h6;
   localparam logic [3:0] CMD_CLEAR_STATUS = 4'h7;
   localparam logic [3:0] CMD_SUSPEND = 4'h8;
   localparam logic [3:0] CMD_RESUME = 4'h9;
   localparam logic [3:0] CMD_BUS_READ = 4'hA;
   localparam logic [3:0] CMD_RESET = 4'hB;

   // ************************************************************
   // Wishbone register offsets (byte addresses)
   // ************************************************************
   localparam logic [4:0] REG_CONTROL = 5'h00;
   localparam logic [4:0] REG_ADDRESS = 5'h04;
   localparam logic [4:0] REG_DATA = 5'h08;
   localparam logic [4:0] REG_DATA2 = 5'h0C;
   localparam logic [4:0] REG_STATUS = 5'h10;
   localparam logic [4:0] REG_READ_DATA = 5'h14;
   localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

   // ************************************************************
   // Timing, figures in ns and the clock cycles rounded up from them
   // ************************************************************
   localparam int CLK_PERIOD_NS = 5;
   localparam int GLITCH_NS = 5;
   localparam int STROBE_LOW_NS = 50;
   localparam int SETUP_NS = 20;
   localparam int HOLD_NS = 20;
   localparam int READ_ACCESS_NS = 100;
   localparam int RESET_LOW_NS = 100;
   localparam int RESET_RECOVER_NS = 150;
   localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_LOW_CYC = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_RECOVER_CYC = (RESET_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMER_W = 8;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic chip_sel_n;
      logic out_gate_n;
      logic write_n;
      logic hard_reset_n;
   } strobes_type;

   typedef enum logic [2:0] {
      PH_IDLE, PH_SETUP, PH_LOW, PH_HOLD, PH_READ, PH_GAP, PH_RESET, PH_RECOVER
   } phase_type;

endpackage : flash_host_pkg

// File: flash_bus_command_host_assertions.sv
// Concurrent checks of the flash host Wishbone and pin timing
module flash_bus_command_host_assertions
   import flash_host_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [ADDR_W-1:0] word_address_in_o,
   input wire logic [DATA_W-1:0] data_io_bus_o,
   input wire logic data_io_bus_oe_o,
   input wire logic [DATA_W-1:0] data_io_bus_i,
   input wire logic chip_sel_n_o,
   input wire logic out_gate_n_o,
   input wire logic write_n_o,
   input wire logic hard_reset_n_o
);
   // ************************************************************
   // Pin and bus properties
   // ************************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack did not pulse once a cycle after the request");
   chk_write_gate: assert property (!write_n_o |-> !chip_sel_n_o && out_gate_n_o && hard_reset_n_o)
      else $error("write strobe low without select or with gate low");
   chk_write_data: assert property (!write_n_o |-> data_io_bus_oe_o && $stable(data_io_bus_o))
      else $error("write data not driven steady while write strobe low");
   chk_select_hold: assert property ($rose(write_n_o) |-> !chip_sel_n_o [*3])
      else $error("select rose before the write strobe");
   chk_read_release: assert property (!out_gate_n_o |-> !data_io_bus_oe_o && !chip_sel_n_o && write_n_o)
      else $error("gate low while host drives data or select high");
   chk_reset_quiet: assert property (!hard_reset_n_o |-> chip_sel_n_o && out_gate_n_o && write_n_o)
      else $error("strobes active during reset pulse");
   chk_strobe_width: assert property ($fell(write_n_o) |-> !write_n_o [*8])
      else $error("write strobe pulse too short");
   chk_select_width: assert property ($fell(chip_sel_n_o) |-> !chip_sel_n_o [*4])
      else $error("select pulse too short");
   chk_reset_width: assert property ($fell(hard_reset_n_o) |-> !hard_reset_n_o [*8])
      else $error("reset pulse too short");
endmodule : flash_bus_command_host_assertions

bind flash_bus_command_host flash_bus_command_host_assertions flash_bus_command_host_assertions_inst (
   .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .word_address_in_o(word_address_in_o), .data_io_bus_o(data_io_bus_o), .data_io_bus_oe_o(data_io_bus_oe_o),
   .data_io_bus_i(data_io_bus_i), .chip_sel_n_o(chip_sel_n_o), .out_gate_n_o(out_gate_n_o),
   .write_n_o(write_n_o), .hard_reset_n_o(hard_reset_n_o));

// File: flash_device_model.sv
// Behavioural model of the flash device on the far side of the host
module flash_device_model
   import flash_host_pkg::*;
#(
   parameter logic [15:0] MAKER_CODE = 16'h00A5, // Arbitrary value
   parameter logic [15:0] PART_CODE = 16'h005A, // Arbitrary value
   parameter logic [15:0] QUERY_BASE = 16'h3C00,
   parameter int PROG_NS = 600,
   parameter int ERASE_NS = 800
)
(
   input wire logic [ADDR_W-1:0] word_address_in_i,
   input wire logic [DATA_W-1:0] data_io_bus_i,
   output logic [DATA_W-1:0] data_io_bus_o,
   output logic data_io_bus_oe_o,
   input wire logic chip_sel_n_i,
   input wire logic out_gate_n_i,
   input wire logic write_n_i,
   input wire logic hard_reset_n_i,
   input wire logic unlock_i
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [int];
   logic [7:0] status = 8'h00;
   int mode = 0;
   int pend = 0;
   int left = 0;
   logic suspended = 1'b0;
   logic locked = 1'b1;
   logic armed = 1'b0;
   logic [19:0] first_adr;
   logic [15:0] first_dat;
   time armed_at;
   // ************************************************************
   // Command interpreter
   // ************************************************************
   task automatic take(input logic [19:0] adr, input logic [15:0] dat);
      if (pend == 1) begin
         pend = 0;
         mode = 1;
         if (dat[7:0] != OP_ERASE_CONFIRM) status = status | 8'h30;
         else if (locked) status = status | 8'h22;
         else begin
            foreach (mem[k]) if ((k >> 15) == (adr >> 15)) mem[k] = 16'hFFFF;
            left = ERASE_NS;
         end
      end else if (pend == 2 || pend == 4) begin
         mode = 1;
         if (locked || (pend == 4 && adr != (first_adr ^ 20'h00001))) status = status | 8'h12;
         else begin
            if (pend == 4) mem[first_adr] = first_dat;
            mem[adr] = dat;
            left = PROG_NS;
         end
         pend = 0;
      end else if (pend == 3) begin
         first_adr = adr;
         first_dat = dat;
         pend = 4;
      end else if (left > 0 && !suspended) begin
         if (dat[7:0] == OP_READ_STATUS) mode = 1;
         if (dat[7:0] == OP_SUSPEND) suspended = 1'b1;
      end else case (dat[7:0])
         OP_READ_ARRAY: mode = 0;
         OP_READ_STATUS: mode = 1;
         OP_READ_SIGNATURE: mode = 2;
         OP_READ_QUERY: mode = 3;
         OP_CLEAR_STATUS: status = status & 8'hC5;
         OP_RESUME: begin
            suspended = 1'b0;
            mode = 1;
         end
         OP_ERASE_SETUP: pend = suspended ? 0 : 1;
         OP_PROGRAM: pend = 2;
         OP_DOUBLE_PROGRAM: pend = 3;
         default: mode = 0;
      endcase
   endtask : take

   // Read word chosen by mode, status while the controller runs
   function automatic logic [15:0] read_word(input logic [19:0] adr);
      logic run;
      run = left > 0 && !suspended;
      if (run || mode == 1) return {8'h00, !run, status[6:0]};
      if (mode == 2) return adr[0] ? PART_CODE : MAKER_CODE;
      if (mode == 3) return QUERY_BASE ^ adr[15:0];
      return mem.exists(adr) ? mem[adr] : 16'hFFFF;
   endfunction : read_word

   // Drive only with select and gate low and reset high
   assign data_io_bus_oe_o = !chip_sel_n_i && !out_gate_n_i && hard_reset_n_i;
   always #1 data_io_bus_o = read_word(word_address_in_i);
   // Controller time, frozen while paused
   always #5 if (left > 0 && !suspended) left = left - 5;
   // Reset pin aborts work, returns to read mode and locks all blocks
   always @(negedge hard_reset_n_i) begin
      mode = 0;
      pend = 0;
      left = 0;
      suspended = 1'b0;
      locked = 1'b1;
      armed = 1'b0;
   end
   always @(posedge unlock_i) locked = 1'b0;
   // Write begins with select and strobe low, gate high
   always @(chip_sel_n_i or write_n_i or out_gate_n_i) begin
      if (!chip_sel_n_i && !write_n_i && out_gate_n_i && hard_reset_n_i && !armed) begin
         armed = 1'b1;
         armed_at = $time;
      end
   end
   // Latch on whichever strobe rises first, glitches dropped
   always @(posedge write_n_i or posedge chip_sel_n_i) begin
      if (armed) begin
         armed = 1'b0;
         if ($time - armed_at >= 5) take(word_address_in_i, data_io_bus_i);
      end
   end
endmodule : flash_device_model

// File: test_flash_bus_command_host.sv
// Self-checking bench of the flash host against a behavioural flash model
module test_flash_bus_command_host import flash_host_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [15:0] MAKER = 16'h00A5; // Arbitrary value
   localparam logic [15:0] PART = 16'h005A; // Arbitrary value
   localparam logic [15:0] QBASE = 16'h3C00;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [4:0] wb_adr_i = 5'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic [3:0] wb_sel_i = 4'hF;
   logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o, unlock = 1'b0;
   logic [ADDR_W-1:0] word_address_in_o;
   logic [DATA_W-1:0] data_io_bus_o, dev_dq, last_dq = 16'h0000;
   logic data_io_bus_oe_o, dev_oe, chip_sel_n_o, out_gate_n_o, write_n_o, hard_reset_n_o;
   wire logic [DATA_W-1:0] dq_wire = data_io_bus_oe_o ? data_io_bus_o : (dev_oe ? dev_dq : ~last_dq);
   int fail_count = 0;
   int comparisons = 0;
   logic [15:0] exp_mem [int];
   logic [19:0] a, b;
   logic [15:0] d, e;
   logic [31:0] rd;
   // ************************************************************
   // Clock, wire resolution and instances
   // ************************************************************
   always #2.5 clk_i = ~clk_i;
   always @(posedge clk_i) last_dq <= dq_wire;
   flash_bus_command_host flash_bus_command_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .word_address_in_o(word_address_in_o),
      .data_io_bus_o(data_io_bus_o), .data_io_bus_oe_o(data_io_bus_oe_o), .data_io_bus_i(dq_wire),
      .chip_sel_n_o(chip_sel_n_o), .out_gate_n_o(out_gate_n_o), .write_n_o(write_n_o),
      .hard_reset_n_o(hard_reset_n_o));
   flash_device_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .QUERY_BASE(QBASE)) flash_device_model_inst (
      .word_address_in_i(word_address_in_o), .data_io_bus_i(dq_wire), .data_io_bus_o(dev_dq),
      .data_io_bus_oe_o(dev_oe), .chip_sel_n_i(chip_sel_n_o), .out_gate_n_i(out_gate_n_o),
      .write_n_i(write_n_o), .hard_reset_n_i(hard_reset_n_o), .unlock_i(unlock));
   // Compare one result
   task automatic check(input logic [31:0] got, input logic [31:0] want);
      comparisons++;
      if (got !== want) begin
         fail_count++;
         $display("[FAIL] %0t ns: got %h expected %h", $time, got, want);
      end
   endtask : check
   // Classic single Wishbone cycle, held until ack
   task automatic wb(input logic [4:0] adr, input logic we, input logic [31:0] dat);
      int n;
      wb_adr_i <= adr;
      wb_we_i <= we;
      wb_dat_i <= dat;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 40);
      if (wb_ack_o !== 1'b1) begin
         fail_count++;
         $display("[FAIL] %0t ns: no ack", $time);
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   // Start a host command and poll until it is done
   task automatic issue(input logic [3:0] cmd);
      int n;
      wb(REG_CONTROL, 1'b1, {28'h0, cmd});
      n = 0;
      do begin
         wb(REG_STATUS, 1'b0, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 100);
      if (rd[0] !== 1'b0) begin
         fail_count++;
         $display("[FAIL] %0t ns: command never finished", $time);
      end
   endtask : issue
   task automatic bus_read(input logic [19:0] adr, input logic [15:0] want);
      wb(REG_ADDRESS, 1'b1, {12'h000, adr});
      issue(CMD_BUS_READ);
      wb(REG_READ_DATA, 1'b0, 32'h0);
      check(rd, {16'h0000, want});
   endtask : bus_read
   task automatic prog(input logic [19:0] adr, input logic [15:0] dat);
      wb(REG_ADDRESS, 1'b1, {12'h000, adr});
      wb(REG_DATA, 1'b1, {16'h0000, dat});
      issue(CMD_PROGRAM);
      exp_mem[adr] = dat;
   endtask : prog
   function automatic logic [15:0] emem(input logic [19:0] adr);
      return exp_mem.exists(adr) ? exp_mem[adr] : 16'hFFFF;
   endfunction : emem
   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run
   // ************************************************************
   // Scenarios
   // ************************************************************
   initial begin
      void'($urandom(67));
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int r = 0; r < 7; r++) begin
         wb(5'(r * 4), 1'b0, 32'h0);
         check(rd, RESET_VALUE);
      end
      a = {5'h03, 15'($urandom)};
      bus_read(a, 16'hFFFF);
      wb(REG_ADDRESS, 1'b1, {12'h000, a});
      issue(CMD_ERASE);
      bus_read(a, 16'h00A2);
      issue(CMD_CLEAR_STATUS);
      bus_read(a, 16'h0080);
      unlock <= 1'b1;
      prog(a, 16'($urandom));
      bus_read(a, 16'h0000);
      repeat (200) @(posedge clk_i);
      issue(CMD_READ_ARRAY);
      bus_read(a, emem(a));
      b = {5'h05, 15'($urandom)};
      d = 16'($urandom);
      e = 16'($urandom);
      wb(REG_DATA2, 1'b1, {16'h0000, e});
      prog(b, d);
      repeat (200) @(posedge clk_i); // Single program must end first
      issue(CMD_DOUBLE_PROGRAM);
      exp_mem[b ^ 20'h00001] = e;
      repeat (200) @(posedge clk_i);
      issue(CMD_READ_ARRAY);
      bus_read(b, emem(b));
      bus_read(b ^ 20'h00001, emem(b ^ 20'h00001));
      b = {5'h07, 15'($urandom)};
      prog(b, e);
      issue(CMD_SUSPEND);
      bus_read(b, 16'h0080);
      issue(CMD_RESUME);
      bus_read(b, 16'h0000);
      repeat (200) @(posedge clk_i);
      issue(CMD_READ_ARRAY);
      bus_read(b, emem(b));
      wb(REG_ADDRESS, 1'b1, {12'h000, a});
      issue(CMD_ERASE);
      issue(CMD_READ_SIGNATURE);
      bus_read(a, 16'h0000);
      repeat (300) @(posedge clk_i);
      foreach (exp_mem[k]) if ((k >> 15) == 3) exp_mem[k] = 16'hFFFF;
      issue(CMD_READ_ARRAY);
      bus_read(a, emem(a));
      issue(CMD_READ_SIGNATURE);
      bus_read(20'h00000, MAKER);
      bus_read(20'h00001, PART);
      issue(CMD_READ_QUERY);
      bus_read(a, QBASE ^ a[15:0]);
      issue(CMD_READ_STATUS);
      bus_read(b, 16'h0080);
      wb(REG_CONTROL, 1'b1, 32'h0000_000C);
      wb(REG_STATUS, 1'b0, 32'h0);
      check({31'h0, rd[1]}, 32'h1);
      issue(CMD_RESET);
      bus_read(b, emem(b));
      complete_run;
   end
   // Watchdog against a hung handshake
   initial begin
      repeat (30000) @(posedge clk_i);
      fail_count++;
      complete_run;
   end
endmodule : test_flash_bus_command_host
